// *** rtl/wdt_pkg.sv ***
// Package of register map, reset values, timing constants and state types for the watchdog
package wdt_pkg;

	localparam logic [15:0] ADDR_CLEAR_KEY = 16'hF00E;
	localparam logic [15:0] ADDR_PERIOD_SEL = 16'hF00F;
	localparam logic [15:0] ADDR_IRQ_STATUS = 16'hF010;
	localparam logic [15:0] ADDR_IRQ_MASK = 16'hF011;

	localparam logic [7:0] CLEAR_KEY_RESET = 8'h00;
	localparam logic [7:0] PERIOD_SEL_RESET = 8'h02;
	localparam logic [7:0] KEY_FIRST = 8'h5A;
	localparam logic [7:0] KEY_SECOND = 8'hA5;

	localparam int PTR_BIT = 0;
	localparam int PERIOD_LSB = 0;
	localparam int PERIOD_W = 2;

	localparam int IRQ_W = 2;
	localparam int IRQ_FIRST_OVF = 0;
	localparam int IRQ_CLEARED = 1;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

	localparam int CLK_PERIOD_NS = 50;
	localparam int LS_TICK_PERIOD_NS = 3906250;
	localparam int LS_TICK_CYCLES = LS_TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int HOLD_TIME_NS = 15260;
	localparam int HOLD_CYCLES = (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_W = 9;

	localparam int COUNT_W = 11;
	localparam logic [COUNT_W-1:0] COUNT_RESET = 11'h000;
	localparam logic [COUNT_W-1:0] TC_LAST_125MS = 11'h01F;
	localparam logic [COUNT_W-1:0] TC_LAST_500MS = 11'h07F;
	localparam logic [COUNT_W-1:0] TC_LAST_2S = 11'h1FF;
	localparam logic [COUNT_W-1:0] TC_LAST_8S = 11'h7FF;

	typedef enum logic [1:0] {ST_WAIT_OSC, ST_WARN, ST_HOLD, ST_ALERT} wdt_state_t;

	function automatic logic [COUNT_W-1:0] tc_last(input logic [PERIOD_W-1:0] sel);
		logic [COUNT_W-1:0] r;
		r = TC_LAST_2S;
		case (sel)
			2'h0: r = TC_LAST_125MS;
			2'h1: r = TC_LAST_500MS;
			2'h2: r = TC_LAST_2S;
			default: r = TC_LAST_8S;
		endcase
		return r;
	endfunction

endpackage

// *** rtl/wdt_divider.sv ***
// Clock-enable divider that gives a one-cycle tick every DIV enabled cycles
`timescale 1ns/1ps
module wdt_divider #(
	parameter int DIV = 78125
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic en_i,
	output logic tick_o
);
	localparam int W = $clog2(DIV);

	typedef struct packed {
		logic [W-1:0] cnt;
		logic tick;
	} wdt_div_st_t;

	wdt_div_st_t s_reg;
	wdt_div_st_t s_next;

	always_comb
	begin
		s_next = s_reg;
		s_next.tick = 1'b0;
		// Phase is kept while disabled so a pause does not restart the period
		if (en_i)
		begin
			if (s_reg.cnt == W'(DIV - 1))
			begin
				s_next.cnt = '0;
				s_next.tick = 1'b1;
			end
			else
			begin
				s_next.cnt = W'(s_reg.cnt + W'(1));
			end
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign tick_o = s_reg.tick;
endmodule

// *** rtl/wdt_irq.sv ***
// Sticky event status with write-one-to-clear, mask and one level interrupt
`timescale 1ns/1ps
module wdt_irq (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [wdt_pkg::IRQ_W-1:0] event_i,
	input wire logic wr_status_i,
	input wire logic wr_mask_i,
	input wire logic [wdt_pkg::IRQ_W-1:0] wdata_i,
	output logic [wdt_pkg::IRQ_W-1:0] status_o,
	output logic [wdt_pkg::IRQ_W-1:0] mask_o,
	output logic irq_o
);
	import wdt_pkg::*;

	typedef struct packed {
		logic [IRQ_W-1:0] status;
		logic [IRQ_W-1:0] mask;
	} wdt_irq_st_t;

	wdt_irq_st_t s_reg;
	wdt_irq_st_t s_next;

	always_comb
	begin
		s_next = s_reg;
		if (wr_status_i)
			s_next.status = s_reg.status & ~wdata_i;
		// Set after clear so an event in the clearing cycle is kept
		s_next.status = s_next.status | event_i;
		if (wr_mask_i)
			s_next.mask = wdata_i;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			s_reg.status <= IRQ_RESET;
			s_reg.mask <= IRQ_RESET;
		end
		else
			s_reg <= s_next;
	end

	assign status_o = s_reg.status;
	assign mask_o = s_reg.mask;
	assign irq_o = |(s_reg.status & s_reg.mask);
endmodule

// *** rtl/wdt_top.sv ***
// Two-stage watchdog: keyed clear, period select, warning interrupt then reset
// What this block does
// - Starts by itself after reset release; software cannot stop it.
// - First overflow without a clear raises the non-maskable interrupt request.
// - Second overflow without a valid clear asserts the watchdog reset.
// - Period field 00/01/10/11 selects 125ms, 500ms, 2s, 8s.
// - Period-select register resets to 02H, giving 2s.
// - Reading the clear register returns the sequence pointer on bit 0.
// - Pointer zero on reset and overflow; toggles on every accepted clear-register write.
// - Clear needs 5AH with pointer 0, then A5H with pointer 1.
// - Half a low-speed period after first overflow, clear-register writes ignored, pointer held.
// - Counter advances on the 256 Hz tick once the slow oscillator runs.
// - Counter stops while the chip is in STOP mode.
// - Counting continues in HALT; the interrupt request releases HALT.
`timescale 1ns/1ps
module wdt_top #(
	parameter int LS_TICK_DIV = wdt_pkg::LS_TICK_CYCLES
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [15:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic low_speed_osc_running_i,
	input wire logic stop_mode_i,
	output logic watchdog_nmi_request_o,
	output logic watchdog_reset_o,
	output logic halt_release_o,
	output logic irq_o
);
	import wdt_pkg::*;

	typedef struct packed {
		wdt_state_t state;
		logic [COUNT_W-1:0] count;
		logic ptr;
		logic key1_ok;
		logic [HOLD_W-1:0] hold_cnt;
		logic [HOLD_W-1:0] hold_age;
		logic [PERIOD_W-1:0] period;
		logic [7:0] rdata;
		logic nmi;
		logic rst_pulse;
	} wdt_st_t;

	wdt_st_t s_reg;
	wdt_st_t s_next;

	logic low_speed_tick;
	logic tick_en;
	logic key_wr;
	logic key_open;
	logic clear_ok;
	logic counting;
	logic tc_hit;
	logic ovf;
	logic [IRQ_W-1:0] irq_events;
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_mask;

	// Tick source stands still in STOP and until the slow oscillator runs
	assign tick_en = low_speed_osc_running_i & ~stop_mode_i;

	wdt_divider #(
		.DIV(LS_TICK_DIV)
	) u_tick (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.en_i(tick_en),
		.tick_o(low_speed_tick)
	);

	assign key_wr = wr_i && (addr_i == ADDR_CLEAR_KEY);
	assign key_open = (s_reg.state != ST_HOLD);
	assign clear_ok = key_wr && key_open && s_reg.ptr && s_reg.key1_ok
		&& (wdata_i == KEY_SECOND);
	// A tick already issued when STOP rises is dropped, so the count cannot creep on
	assign counting = low_speed_tick && !stop_mode_i
		&& ((s_reg.state == ST_WARN) || (s_reg.state == ST_ALERT));
	assign tc_hit = (s_reg.count == tc_last(s_reg.period));
	// A clear landing on the overflow tick wins, the software was in time
	assign ovf = counting && tc_hit && !clear_ok;

	always_comb
	begin
		s_next = s_reg;
		s_next.nmi = 1'b0;
		s_next.rst_pulse = 1'b0;
		s_next.rdata = 8'h00;
		// Cycles spent in hold, counted apart from the down-counter for checking
		if (s_reg.state == ST_HOLD)
			s_next.hold_age = HOLD_W'(s_reg.hold_age + 9'h001);
		else
			s_next.hold_age = '0;

		if (key_wr && key_open)
		begin
			s_next.ptr = ~s_reg.ptr;
			s_next.key1_ok = !s_reg.ptr && (wdata_i == KEY_FIRST);
		end
		if (wr_i && (addr_i == ADDR_PERIOD_SEL))
			s_next.period = wdata_i[PERIOD_LSB +: PERIOD_W];

		case (s_reg.state)
			ST_WAIT_OSC:
			begin
				if (low_speed_osc_running_i)
					s_next.state = ST_WARN;
			end
			ST_WARN:
			begin
				if (clear_ok)
					s_next.count = COUNT_RESET;
				else if (ovf)
				begin
					s_next.count = COUNT_RESET;
					s_next.ptr = 1'b0;
					s_next.key1_ok = 1'b0;
					s_next.nmi = 1'b1;
					s_next.hold_cnt = HOLD_W'(HOLD_CYCLES - 1);
					s_next.state = ST_HOLD;
				end
				else if (counting)
					s_next.count = COUNT_W'(s_reg.count + 11'h001);
			end
			ST_HOLD:
			begin
				s_next.count = COUNT_RESET;
				s_next.ptr = 1'b0;
				s_next.key1_ok = 1'b0;
				if (s_reg.hold_cnt == '0)
					s_next.state = ST_ALERT;
				else
					s_next.hold_cnt = HOLD_W'(s_reg.hold_cnt - 9'h001);
			end
			ST_ALERT:
			begin
				if (clear_ok)
				begin
					s_next.count = COUNT_RESET;
					s_next.state = ST_WARN;
				end
				else if (ovf)
				begin
					// Chip reset follows; back to warning in case the pulse is ignored
					s_next.count = COUNT_RESET;
					s_next.ptr = 1'b0;
					s_next.key1_ok = 1'b0;
					s_next.rst_pulse = 1'b1;
					s_next.state = ST_WARN;
				end
				else if (counting)
					s_next.count = COUNT_W'(s_reg.count + 11'h001);
			end
			default:
			begin
				s_next.state = ST_WAIT_OSC;
			end
		endcase

		if (rd_i)
		begin
			case (addr_i)
				ADDR_CLEAR_KEY: s_next.rdata = {7'h00, s_reg.ptr};
				ADDR_PERIOD_SEL: s_next.rdata = {6'h00, s_reg.period};
				ADDR_IRQ_STATUS: s_next.rdata = {6'h00, irq_status};
				ADDR_IRQ_MASK: s_next.rdata = {6'h00, irq_mask};
				default: s_next.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			s_reg.state <= ST_WAIT_OSC;
			s_reg.count <= COUNT_RESET;
			s_reg.ptr <= CLEAR_KEY_RESET[PTR_BIT];
			s_reg.key1_ok <= 1'b0;
			s_reg.hold_cnt <= '0;
			s_reg.hold_age <= '0;
			s_reg.period <= PERIOD_SEL_RESET[PERIOD_LSB +: PERIOD_W];
			s_reg.rdata <= 8'h00;
			s_reg.nmi <= 1'b0;
			s_reg.rst_pulse <= 1'b0;
		end
		else
			s_reg <= s_next;
	end

	assign irq_events = {clear_ok, ovf && (s_reg.state == ST_WARN)};

	wdt_irq u_irq (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.event_i(irq_events),
		.wr_status_i(wr_i && (addr_i == ADDR_IRQ_STATUS)),
		.wr_mask_i(wr_i && (addr_i == ADDR_IRQ_MASK)),
		.wdata_i(wdata_i[IRQ_W-1:0]),
		.status_o(irq_status),
		.mask_o(irq_mask),
		.irq_o(irq_o)
	);

	assign rdata_o = s_reg.rdata;
	assign watchdog_nmi_request_o = s_reg.nmi;
	assign watchdog_reset_o = s_reg.rst_pulse;
	assign halt_release_o = s_reg.nmi;

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	a_never_stops: assert property (
		(s_reg.state != ST_WAIT_OSC) |=> (s_reg.state != ST_WAIT_OSC))
		else $error("watchdog fell back to waiting state");

	a_nmi_first_ovf: assert property (
		(ovf && s_reg.state == ST_WARN) |=> (watchdog_nmi_request_o && !watchdog_reset_o))
		else $error("first overflow gave no interrupt request");

	a_reset_second_ovf: assert property (
		(ovf && s_reg.state == ST_ALERT) |=> (watchdog_reset_o && !watchdog_nmi_request_o))
		else $error("second overflow gave no reset");

	a_terminal_count: assert property (
		(counting && !clear_ok && s_reg.period == 2'h0 && s_reg.count == 11'h01F)
		|=> (s_reg.count == 11'h000 && s_reg.ptr == 1'b0))
		else $error("125ms period did not wrap at 32 ticks");

	a_period_reset: assert property (
		$fell(rst_i) |-> (s_reg.period == 2'h2))
		else $error("period select not 2s after reset");

	a_pointer_read: assert property (
		(rd_i && addr_i == ADDR_CLEAR_KEY) |=> (rdata_o == {7'h00, $past(s_reg.ptr)}))
		else $error("clear register read did not return pointer");

	a_pointer_toggle: assert property (
		(key_wr && key_open && !ovf) |=> (s_reg.ptr != $past(s_reg.ptr)))
		else $error("accepted write did not toggle pointer");

	a_key_pair_clear: assert property (
		(key_wr && key_open && !s_reg.ptr && wdata_i == KEY_FIRST)
		##1 (key_wr && wdata_i == KEY_SECOND) |=> (s_reg.count == 11'h000))
		else $error("ordered key pair did not clear counter");

	a_hold_ignores: assert property (
		(s_reg.state == ST_HOLD) |=> (s_reg.ptr == 1'b0 && s_reg.count == 11'h000))
		else $error("pointer or counter moved during hold");

	a_hold_length: assert property (
		(s_reg.state == ST_HOLD && s_reg.hold_age == HOLD_W'(HOLD_CYCLES - 1))
		|=> (s_reg.state == ST_ALERT))
		else $error("hold did not end after the half slow period");

	a_hold_not_short: assert property (
		(s_reg.state == ST_HOLD && s_reg.hold_age < HOLD_W'(HOLD_CYCLES - 1))
		|=> (s_reg.state == ST_HOLD))
		else $error("hold ended before the half slow period");

	a_stop_freeze: assert property (
		(stop_mode_i && !clear_ok && s_reg.state != ST_HOLD) |=> $stable(s_reg.count))
		else $error("counter moved in STOP mode");

	a_clear_rearms: assert property (
		(clear_ok && s_reg.state == ST_ALERT) |=> (s_reg.state == ST_WARN))
		else $error("valid clear did not return to warning stage");

	c_first_ovf: cover property (watchdog_nmi_request_o);
	c_second_ovf: cover property (watchdog_reset_o);
	c_clear_in_alert: cover property (clear_ok && s_reg.state == ST_ALERT);
	c_irq_level: cover property (irq_o);
	c_key_burst: cover property (key_wr ##1 clear_ok);
endmodule

// *** bench/tb_top.sv ***
// Self-checking bench for the two-stage watchdog: registers, keyed clear, overflow stages
`timescale 1ns/1ps
module tb_top;
	import wdt_pkg::*;
	// Small divider so that every period fits in a short run
	localparam int DIV = 4;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic [15:0] addr_i = 16'h0000;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic osc_i = 1'b0;
	logic stop_i = 1'b0;
	logic [7:0] rdata;
	logic nmi;
	logic wrst;
	logic halt;
	logic irq;
	int err_total = 0;
	int check_count = 0;
	integer seed = 32'h7d35;
	int n;
	logic [7:0] d;
	logic ptr;

	wdt_top #(.LS_TICK_DIV(DIV)) i_dut (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.addr_i(addr_i),
		.wdata_i(wdata_i),
		.wr_i(wr_i),
		.rd_i(rd_i),
		.rdata_o(rdata),
		.low_speed_osc_running_i(osc_i),
		.stop_mode_i(stop_i),
		.watchdog_nmi_request_o(nmi),
		.watchdog_reset_o(wrst),
		.halt_release_o(halt),
		.irq_o(irq)
	);

	initial
	begin
		forever #25 clk_sys_i = ~clk_sys_i;
	end

	function automatic int ticks(input int sel);
		return 32 << (2 * sel);
	endfunction

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		check_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	task automatic rng(input int v, input int lo, input int hi, input string msg);
		chk({7'h0, v >= lo && v <= hi}, 8'h01, msg);
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge clk_sys_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask

	// Two writes back to back, strobe held high across both
	task automatic wr2(input logic [15:0] a, input logic [7:0] v0, input logic [7:0] v1);
		@(posedge clk_sys_i);
		addr_i <= a;
		wdata_i <= v0;
		wr_i <= 1'b1;
		@(posedge clk_sys_i);
		wdata_i <= v1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, output logic [7:0] v);
		@(posedge clk_sys_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		#1 v = rdata;
	endtask

	task automatic rc(input logic [15:0] a, input logic [7:0] exp, input string msg);
		logic [7:0] v;
		rd(a, v);
		chk(v, exp, msg);
	endtask

	// Counts cycles until the chosen pulse shows, giving up at max
	task automatic wait_pulse(input bit want_rst, input int max, output int cyc);
		cyc = 0;
		do
		begin
			@(posedge clk_sys_i);
			#1 cyc++;
		end while (!((want_rst ? wrst : nmi) === 1'b1) && cyc < max);
	endtask

	// Repeats the first key until the pointer reads one, as a handler must
	task automatic clear_wd;
		logic [7:0] v;
		int k;
		k = 0;
		do
		begin
			wr(ADDR_CLEAR_KEY, KEY_FIRST);
			rd(ADDR_CLEAR_KEY, v);
			k++;
		end while (v !== 8'h01 && k < 4);
		wr(ADDR_CLEAR_KEY, KEY_SECOND);
	endtask

	initial
	begin
		#2_000_000;
		err_total++;
		tally_and_finish();
	end

	initial
	begin
		repeat (4) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		rc(ADDR_CLEAR_KEY, 8'h00, "pointer after reset");
		rc(ADDR_PERIOD_SEL, 8'h02, "period after reset");
		rc(ADDR_IRQ_STATUS, 8'h00, "status after reset");
		rc(ADDR_IRQ_MASK, 8'h00, "mask after reset");
		rc(16'hf012, 8'h00, "unmapped read");
		d = 8'($random(seed));
		wr(ADDR_PERIOD_SEL, d);
		rc(ADDR_PERIOD_SEL, {6'h0, d[1:0]}, "period readback");
		wr(16'hf012, 8'hff);
		wr(ADDR_PERIOD_SEL, 8'h00);
		wait_pulse(0, 300, n);
		chk({7'h0, n == 300}, 8'h01, "counted before oscillator");
		$display("test reset_and_start done");
		osc_i <= 1'b1;
		wait_pulse(0, 300, n);
		rng(n, 31 * DIV, 32 * DIV + 4, "first overflow time");
		chk({5'h0, halt, irq, wrst}, 8'h04, "wake pulse, masked irq");
		wr(ADDR_CLEAR_KEY, KEY_FIRST);
		rc(ADDR_CLEAR_KEY, 8'h00, "pointer toggled in hold");
		wait_pulse(1, 600, n);
		rng(n, HOLD_CYCLES + 31 * DIV - 10, HOLD_CYCLES + 32 * DIV + 4, "second overflow");
		chk({7'h0, nmi}, 8'h00, "nmi beside reset pulse");
		wait_pulse(0, 300, n);
		rng(n, 31 * DIV, 32 * DIV + 4, "warning after reset pulse");
		wr(ADDR_IRQ_MASK, 8'h01);
		repeat (2) @(posedge clk_sys_i);
		#1 chk({7'h0, irq}, 8'h01, "irq with unmasked status");
		wr(ADDR_IRQ_STATUS, 8'h01);
		repeat (2) @(posedge clk_sys_i);
		#1 chk({7'h0, irq}, 8'h00, "irq after status clear");
		repeat (HOLD_CYCLES) @(posedge clk_sys_i);
		clear_wd();
		rc(ADDR_CLEAR_KEY, 8'h00, "pointer after clear pair");
		rc(ADDR_IRQ_STATUS, 8'h02, "valid clear status");
		wait_pulse(0, 300, n);
		chk({6'h0, nmi, wrst}, 8'h02, "stage after clear in alert");
		$display("test two_stage done");
		for (int s = 0; s < 4; s++)
		begin
			repeat (HOLD_CYCLES + 2) @(posedge clk_sys_i);
			clear_wd();
			wr(ADDR_PERIOD_SEL, 8'(s));
			clear_wd();
			wait_pulse(0, ticks(s) * DIV + 50, n);
			rng(n, (ticks(s) - 1) * DIV, ticks(s) * DIV + 4, "selected period");
		end
		$display("test periods done");
		repeat (HOLD_CYCLES + 2) @(posedge clk_sys_i);
		clear_wd();
		wr(ADDR_IRQ_STATUS, 8'h03);
		ptr = 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			d = 8'($random(seed));
			if (d == KEY_FIRST)
				d = 8'h00;
			wr(ADDR_CLEAR_KEY, d);
			ptr = ~ptr;
			rc(ADDR_CLEAR_KEY, {7'h0, ptr}, "pointer toggle");
		end
		wr(ADDR_CLEAR_KEY, KEY_SECOND);
		wr(ADDR_CLEAR_KEY, KEY_FIRST);
		wr(ADDR_CLEAR_KEY, KEY_SECOND);
		rd(ADDR_IRQ_STATUS, d);
		chk(d & 8'h02, 8'h00, "spoiled pair cleared");
		wr(ADDR_CLEAR_KEY, 8'h00);
		wr2(ADDR_CLEAR_KEY, KEY_FIRST, KEY_SECOND);
		rc(ADDR_IRQ_STATUS, 8'h02, "back-to-back pair");
		rc(ADDR_CLEAR_KEY, 8'h00, "pointer after pair");
		$display("test pointer done");
		wr(ADDR_PERIOD_SEL, 8'h00);
		wr(ADDR_CLEAR_KEY, 8'h3c);
		clear_wd();
		stop_i <= 1'b1;
		wait_pulse(0, 600, n);
		chk({7'h0, n == 600}, 8'h01, "counted in stop");
		stop_i <= 1'b0;
		wait_pulse(0, 300, n);
		rng(n, 1, 32 * DIV + 4, "resume after stop");
		$display("test stop done");
		tally_and_finish();
	end
endmodule
